// ===== rtl/motor_lock_pkg.sv
// Shared constants and types for the speed-lock supervision and protection block.
// Assumes one 200 MHz clock; every clock-cycle count below is derived from it.
package motor_lock_pkg;
    // Clock and reference timing
    localparam int CLK_HZ = 200_000_000;
    localparam int CLK_NS = 5;
    localparam int REF_HZ = 1_000_000;
    localparam int REF_DIV = CLK_HZ / REF_HZ;
    localparam int SERVO_DIV = 512;
    localparam int LOCK_BAND = SERVO_DIV / 16;
    localparam int PERIOD_W = 12;
    // Lock protection timing, counted in milliseconds
    localparam int MS_NS = 1_000_000;
    localparam int MS_CYCLES = MS_NS / CLK_NS;
    localparam int PROT_MS_PER_UNIT = 330;
    localparam int STOP_MS_PER_UNIT = 15;
    localparam int DECAY_PER_MS = PROT_MS_PER_UNIT / STOP_MS_PER_UNIT;
    // Direction changeover dead time
    localparam int DEAD_NS = 1000;
    localparam int DEAD_CYCLES = (DEAD_NS + CLK_NS - 1) / CLK_NS;
    // Drive PWM, 8-bit duty
    localparam int PWM_HZ = 17_500;
    localparam int PWM_DIV = CLK_HZ / (PWM_HZ * 256);
    localparam logic [7:0] DUTY_RESET = 8'h80;
    localparam int GAIN_SHIFT = 2;
    // Register map
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] PERIOD_OFS = 8'h08;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_DIR_BIT = 1;
    localparam int CTRL_TMO_LSB = 4;
    localparam logic [3:0] TMO_RESET = 4'ha;
    localparam int ST_LOCK_BIT = 0;
    localparam int ST_ACCEL_BIT = 1;
    localparam int ST_SHUT_BIT = 2;
    localparam int ST_BRAKE_BIT = 3;
    localparam int ST_CHG_BIT = 4;
    localparam int ST_DUTY_LSB = 8;

    typedef struct packed {
        logic [2:0] high;
        logic [2:0] low;
    } drive_s;

    typedef struct packed {
        logic [3:0] timeout;
        logic dirRev;
        logic run;
    } ctrl_s;

    typedef enum logic [2:0] {
        ST_STOP = 3'b001,
        ST_RUN = 3'b010,
        ST_DEAD = 3'b100
    } mode_e;
endpackage : motor_lock_pkg

// ===== rtl/speed_discriminator.sv
// Tacho period measurement and speed discrimination against the servo target.
// Assumes refTick is a one-cycle pulse at the reference rate and tacho is synchronous.
`timescale 1ns/1ps
module speed_discriminator
    import motor_lock_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Timing and sensor
    input wire logic refTick,
    input wire logic tachoPulse,
    // Results
    output logic measValid,
    output logic [PERIOD_W-1:0] period,
    output logic lock,
    output logic accel
);
    localparam logic [PERIOD_W-1:0] TARGET = PERIOD_W'(SERVO_DIV);
    localparam logic [PERIOD_W-1:0] BAND = PERIOD_W'(LOCK_BAND);

    logic tachoPrev_q, tachoPrev_d;
    logic [PERIOD_W-1:0] cnt_q, cnt_d, period_q, period_d;
    logic valid_q, valid_d, lock_q, lock_d, accel_q, accel_d;
    logic edgeSeen;

    always_comb begin
        tachoPrev_d = tachoPulse;
        edgeSeen = tachoPulse && !tachoPrev_q;
        cnt_d = cnt_q;
        period_d = period_q;
        valid_d = 1'b0;
        lock_d = lock_q;
        accel_d = accel_q;
        if (edgeSeen) begin
            period_d = cnt_q;
            cnt_d = '0;
            valid_d = 1'b1;
            // Target period is 512 reference clocks; band is one sixteenth of it
            lock_d = (cnt_q >= TARGET - BAND) && (cnt_q <= TARGET + BAND); // RULE_13 RULE_01
            accel_d = cnt_q > TARGET; // RULE_12
        end else if (refTick && cnt_q != '1) begin
            cnt_d = cnt_q + 1'b1;
        end
        // A stalled motor never produces an edge, so drop lock once overdue
        if (cnt_q > TARGET + BAND) begin
            lock_d = 1'b0; // RULE_01
            accel_d = 1'b1; // RULE_12
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tachoPrev_q <= 1'b0;
            cnt_q <= '0;
            period_q <= '0;
            valid_q <= 1'b0;
            lock_q <= 1'b0;
            accel_q <= 1'b1;
        end else begin
            tachoPrev_q <= tachoPrev_d;
            cnt_q <= cnt_d;
            period_q <= period_d;
            valid_q <= valid_d;
            lock_q <= lock_d;
            accel_q <= accel_d;
        end
    end

    assign measValid = valid_q;
    assign period = period_q;
    assign lock = lock_q;
    assign accel = accel_q;
endmodule : speed_discriminator

// ===== rtl/motor_speed_lock_protect.sv
// Speed-lock supervision, duty control, direction changeover and lock protection.
// Assumes synchronous Hall, tacho and over-current inputs and an APB master on clk.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01 - Lock flag low while speed is within 6.25 percent of target
// RULE_02 - Outside the band, duty moves in proportion to the speed error
// RULE_03 - Direction comes from the control bit and may change while running
// RULE_04 - During changeover no phase has high and low side on together
// RULE_05 - Over-current after changeover: low sides off, high sides short-brake
// RULE_06 - Controller avoids reversing at high speed; brake current may exceed 2.5 A
// RULE_07 - Running and unlocked for the timeout turns all low sides off
// RULE_08 - Shutdown stays latched until stop is commanded
// RULE_09 - Timeout setting zero disables lock protection entirely
// RULE_10 - Short stop only partly resets timer; hold stop 15 ms per unit
// RULE_11 - Drive PWM frequency set between 15 kHz and 20 kHz
// RULE_12 - Discriminator level output: high accelerate, low decelerate
// RULE_13 - Target tacho frequency is reference clock divided by 512
// RULE_14 - Controller commands run or stop; stop disables the drive
// RULE_15 - Protection timer counts reference time, clears on lock, decays in stop
module motor_speed_lock_protect
    import motor_lock_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Motor sensing
    input wire logic [2:0] hall,
    input wire logic tachoPulse,
    input wire logic overCurrent,
    // Drive and status pins
    output motor_lock_pkg::drive_s drive,
    output logic speedLockFlag_n,
    output logic accelOut
);
    import motor_lock_pkg::*;

    localparam logic [15:0] DECAY = 16'(DECAY_PER_MS);
    localparam logic [8:0] DUTY_MAX = 9'h0ff;

    function automatic drive_s commutate(input logic [2:0] h);
        drive_s d;
        d = '0;
        case (h)
            3'b001: d = '{high: 3'b001, low: 3'b010};
            3'b011: d = '{high: 3'b001, low: 3'b100};
            3'b010: d = '{high: 3'b010, low: 3'b100};
            3'b110: d = '{high: 3'b010, low: 3'b001};
            3'b100: d = '{high: 3'b100, low: 3'b001};
            3'b101: d = '{high: 3'b100, low: 3'b010};
            default: d = '0;
        endcase
        return d;
    endfunction : commutate

    // Bus and registers
    ctrl_s ctrl_q, ctrl_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    // Control state
    mode_e mode_q, mode_d;
    logic dirApplied_q, dirApplied_d;
    logic [7:0] dead_q, dead_d;
    logic revPending_q, revPending_d, brake_q, brake_d, shutdown_q, shutdown_d;
    logic [7:0] duty_q, duty_d, pwmCnt_q, pwmCnt_d;
    logic [7:0] pwmDiv_q, pwmDiv_d, refDiv_q, refDiv_d;
    logic [31:0] msCnt_q, msCnt_d;
    logic [15:0] protTimer_q, protTimer_d;
    drive_s drive_q, drive_d;
    logic lockFlag_n_q, lockFlag_n_d, accelOut_q, accelOut_d;
    // Discriminator
    logic refTick, msTick, measValid, lock, accel;
    logic [PERIOD_W-1:0] period;
    logic [15:0] protLimit;
    logic signed [PERIOD_W:0] err;
    logic signed [PERIOD_W:0] dutyNext;

    speed_discriminator u_disc (
        .clk(clk),
        .arst_n(arst_n),
        .refTick(refTick),
        .tachoPulse(tachoPulse),
        .measValid(measValid),
        .period(period),
        .lock(lock),
        .accel(accel)
    );

    // APB: the setup edge prepares the answer, so the access phase completes at once
    always_comb begin
        ctrl_d = ctrl_q;
        prdata_d = prdata_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        if (psel && !penable) begin
            pready_d = 1'b1;
            prdata_d = '0;
            if (paddr == CTRL_OFS) begin
                prdata_d[CTRL_TMO_LSB +: 4] = ctrl_q.timeout;
                prdata_d[CTRL_DIR_BIT] = ctrl_q.dirRev;
                prdata_d[CTRL_RUN_BIT] = ctrl_q.run;
            end else if (paddr == STATUS_OFS) begin
                prdata_d[ST_LOCK_BIT] = lock;
                prdata_d[ST_ACCEL_BIT] = accel;
                prdata_d[ST_SHUT_BIT] = shutdown_q;
                prdata_d[ST_BRAKE_BIT] = brake_q;
                prdata_d[ST_CHG_BIT] = (mode_q == ST_DEAD);
                prdata_d[ST_DUTY_LSB +: 8] = duty_q;
            end else if (paddr == PERIOD_OFS) begin
                prdata_d[PERIOD_W-1:0] = period;
            end else begin
                pslverr_d = 1'b1;
            end
            if (pwrite && paddr != CTRL_OFS) begin
                pslverr_d = 1'b1;
            end
        end
        if (psel && penable && pready_q && pwrite && paddr == CTRL_OFS) begin
            ctrl_d.run = pwdata[CTRL_RUN_BIT]; // RULE_14
            ctrl_d.dirRev = pwdata[CTRL_DIR_BIT]; // RULE_03
            ctrl_d.timeout = pwdata[CTRL_TMO_LSB +: 4];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= '{timeout: TMO_RESET, dirRev: 1'b0, run: 1'b0};
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Control: changeover, duty, PWM, protection and the drive pins
    always_comb begin
        refDiv_d = (refDiv_q == 8'(REF_DIV - 1)) ? 8'h00 : refDiv_q + 8'h01;
        refTick = (refDiv_q == 8'(REF_DIV - 1));
        msCnt_d = (msCnt_q == 32'(MS_CYC - 1)) ? 32'h0 : msCnt_q + 32'h1;
        msTick = (msCnt_q == 32'(MS_CYC - 1));
        pwmDiv_d = (pwmDiv_q == 8'(PWM_DIV - 1)) ? 8'h00 : pwmDiv_q + 8'h01;
        pwmCnt_d = (pwmDiv_q == 8'(PWM_DIV - 1)) ? pwmCnt_q + 8'h01 : pwmCnt_q; // RULE_11
        mode_d = mode_q;
        dirApplied_d = dirApplied_q;
        dead_d = dead_q;
        revPending_d = revPending_q;
        brake_d = brake_q;
        shutdown_d = shutdown_q;
        duty_d = duty_q;
        protTimer_d = protTimer_q;
        protLimit = 16'(ctrl_q.timeout) * 16'(PROT_MS_PER_UNIT);
        err = $signed({1'b0, period}) - $signed((PERIOD_W+1)'(SERVO_DIV));
        // As wide as the error, so a long stalled period cannot wrap the sum negative
        dutyNext = $signed({{(PERIOD_W-7){1'b0}}, duty_q}) + (err >>> GAIN_SHIFT);
        case (mode_q)
            ST_STOP: begin
                brake_d = 1'b0;
                revPending_d = 1'b0;
                dirApplied_d = ctrl_q.dirRev;
                if (ctrl_q.run) begin
                    mode_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!ctrl_q.run) begin
                    mode_d = ST_STOP;
                end else if (ctrl_q.dirRev != dirApplied_q) begin
                    mode_d = ST_DEAD; // RULE_03
                    dead_d = 8'(DEAD_CYCLES - 1);
                end
            end
            ST_DEAD: begin
                if (!ctrl_q.run) begin
                    mode_d = ST_STOP;
                end else if (dead_q == 8'h00) begin
                    mode_d = ST_RUN;
                    dirApplied_d = ctrl_q.dirRev;
                    revPending_d = 1'b1;
                end else begin
                    dead_d = dead_q - 8'h01;
                end
            end
            default: mode_d = ST_STOP;
        endcase
        // After a reversal, excess current brakes until it falls again
        if (mode_q == ST_RUN && revPending_q && overCurrent) begin
            brake_d = 1'b1; // RULE_05
        end else if (!overCurrent || mode_q != ST_RUN) begin
            brake_d = 1'b0;
        end
        if (lock) begin
            revPending_d = 1'b0;
        end
        // Proportional duty correction only outside the lock band
        if (measValid && !lock && mode_q == ST_RUN) begin
            if (dutyNext < 10'sd0) begin
                duty_d = 8'h00; // RULE_02
            end else if (dutyNext > $signed({1'b0, DUTY_MAX})) begin
                duty_d = 8'hff; // RULE_02
            end else begin
                duty_d = 8'(dutyNext); // RULE_02
            end
        end
        // Protection timer in ms; decays during stop so a short stop resets it partly
        if (!ctrl_q.run) begin
            shutdown_d = 1'b0; // RULE_08
            if (msTick) begin
                protTimer_d = (protTimer_q > DECAY) ? protTimer_q - DECAY : 16'h0; // RULE_10 RULE_15
            end
        end else if (lock) begin
            protTimer_d = 16'h0; // RULE_15
        end else if (msTick && protTimer_q < protLimit) begin
            protTimer_d = protTimer_q + 16'h1; // RULE_15
        end
        if (ctrl_q.run && ctrl_q.timeout != 4'h0 && protTimer_q >= protLimit) begin
            shutdown_d = 1'b1; // RULE_07 RULE_09
        end
        drive_d = '0;
        if (mode_q == ST_RUN) begin
            drive_d = commutate(dirApplied_q ? ~hall : hall); // RULE_03
            drive_d.low = (pwmCnt_q < duty_q) ? drive_d.low : 3'b000;
            if (brake_q) begin
                drive_d = '{high: 3'b111, low: 3'b000}; // RULE_05
            end
            if (shutdown_q) begin
                drive_d.low = 3'b000; // RULE_07
            end
        end
        // The dead state leaves every switch open before the new direction applies
        drive_d.low = drive_d.low & ~drive_d.high; // RULE_04
        lockFlag_n_d = !lock; // RULE_01
        accelOut_d = accel; // RULE_12
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            refDiv_q <= 8'h00;
            msCnt_q <= 32'h0;
            pwmDiv_q <= 8'h00;
            pwmCnt_q <= 8'h00;
            mode_q <= ST_STOP;
            dirApplied_q <= 1'b0;
            dead_q <= 8'h00;
            revPending_q <= 1'b0;
            brake_q <= 1'b0;
            shutdown_q <= 1'b0;
            duty_q <= DUTY_RESET;
            protTimer_q <= 16'h0;
            drive_q <= '0;
            lockFlag_n_q <= 1'b1;
            accelOut_q <= 1'b1;
        end else begin
            refDiv_q <= refDiv_d;
            msCnt_q <= msCnt_d;
            pwmDiv_q <= pwmDiv_d;
            pwmCnt_q <= pwmCnt_d;
            mode_q <= mode_d;
            dirApplied_q <= dirApplied_d;
            dead_q <= dead_d;
            revPending_q <= revPending_d;
            brake_q <= brake_d;
            shutdown_q <= shutdown_d;
            duty_q <= duty_d;
            protTimer_q <= protTimer_d;
            drive_q <= drive_d;
            lockFlag_n_q <= lockFlag_n_d;
            accelOut_q <= accelOut_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign drive = drive_q;
    assign speedLockFlag_n = lockFlag_n_q;
    assign accelOut = accelOut_q;

    property p_lockFlag;
        @(posedge clk) disable iff (!arst_n) ##1 (lockFlag_n_q == !$past(lock));
    endproperty
    a_lockFlag: assert property (p_lockFlag) else $error("lock flag does not follow lock"); // RULE_01
    property p_noShoot;
        @(posedge clk) disable iff (!arst_n) (drive_q.high & drive_q.low) == 3'b000;
    endproperty
    a_noShoot: assert property (p_noShoot) else $error("high and low side on together"); // RULE_04
    property p_reverse;
        @(posedge clk) disable iff (!arst_n)
            (mode_q == ST_RUN && ctrl_q.run && ctrl_q.dirRev != dirApplied_q)
            |=> (mode_q == ST_DEAD) ##1 (drive_q == '0);
    endproperty
    a_reverse: assert property (p_reverse) else $error("reversal skipped dead time"); // RULE_03
    property p_brake;
        @(posedge clk) disable iff (!arst_n)
            (brake_q && mode_q == ST_RUN) |=> (drive_q.low == 3'b000 && drive_q.high == 3'b111);
    endproperty
    a_brake: assert property (p_brake) else $error("short brake not applied"); // RULE_05
    property p_shutLow;
        @(posedge clk) disable iff (!arst_n) shutdown_q |=> drive_q.low == 3'b000;
    endproperty
    a_shutLow: assert property (p_shutLow) else $error("low side on during shutdown"); // RULE_07
    property p_latch;
        @(posedge clk) disable iff (!arst_n) (shutdown_q && ctrl_q.run) |=> shutdown_q;
    endproperty
    a_latch: assert property (p_latch) else $error("shutdown released while running"); // RULE_08
    property p_disabled;
        @(posedge clk) disable iff (!arst_n)
            (ctrl_q.timeout == 4'h0 && !shutdown_q) |=> !shutdown_q;
    endproperty
    a_disabled: assert property (p_disabled) else $error("shutdown with protection off"); // RULE_09
    property p_decay;
        @(posedge clk) disable iff (!arst_n)
            (!ctrl_q.run && msTick && protTimer_q > DECAY) |=> protTimer_q == $past(protTimer_q) - DECAY;
    endproperty
    a_decay: assert property (p_decay) else $error("timer decay wrong in stop"); // RULE_10
    property p_accel;
        @(posedge clk) disable iff (!arst_n) ##1 (accelOut_q == $past(accel));
    endproperty
    a_accel: assert property (p_accel) else $error("accel pin does not follow"); // RULE_12
    c_shutdown: cover property (@(posedge clk) disable iff (!arst_n) $rose(shutdown_q));
    c_reverse: cover property (@(posedge clk) disable iff (!arst_n) mode_q == ST_DEAD ##1 mode_q == ST_RUN);
    c_brake: cover property (@(posedge clk) disable iff (!arst_n) $rose(brake_q));
endmodule : motor_speed_lock_protect

// ===== test/motor_model.sv
// Behavioural motor: tacho square wave and six-step Hall code.
// Assumes the bench sets periodCyc in clk cycles; zero means a stalled rotor.
`timescale 1ns/1ps
module motor_model (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Speed command from the bench
    input wire logic [31:0] periodCyc,
    // Sensor outputs
    output logic [2:0] hall,
    output logic tachoPulse
);
    logic [31:0] cnt_q;
    logic [2:0] step_q;
    logic [2:0] hallCode [6] = '{3'b001, 3'b011, 3'b010, 3'b110, 3'b100, 3'b101};
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
            step_q <= '0;
        end else if (periodCyc == 0) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= (cnt_q >= periodCyc - 1) ? '0 : cnt_q + 1;
            if (cnt_q == 0) begin
                step_q <= (step_q == 3'd5) ? 3'd0 : step_q + 3'd1;
            end
        end
    end
    // A stalled rotor gives no edges, so the line rests low instead of holding a stale level
    assign tachoPulse = (periodCyc != 0) && (cnt_q < periodCyc / 2);
    assign hall = hallCode[step_q];
endmodule : motor_model

// ===== test/tb.sv
// Bench for the speed-lock block: APB tasks, motor model, sequences of checks.
// Assumes MS_CYC is shortened to 5 so one timeout unit is 1650 cycles.
`timescale 1ns/1ps
module tb;
    import motor_lock_pkg::*;
    localparam int MSC = 5;
    // Clock cycles per timeout setting unit
    localparam int UNIT = PROT_MS_PER_UNIT * MSC;
    // Inside the lock band, below target
    localparam int LOCKED_TICKS = SERVO_DIV - 26;
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr, overCurrent, tachoPulse;
    logic speedLockFlag_n, accelOut, hallBad;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, periodCyc, d, d0;
    logic [2:0] modelHall, hall;
    drive_s drive;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    assign hall = hallBad ? 3'b000 : modelHall;
    motor_speed_lock_protect #(.MS_CYC(MSC)) uut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hall(hall), .tachoPulse(tachoPulse), .overCurrent(overCurrent), .drive(drive),
        .speedLockFlag_n(speedLockFlag_n), .accelOut(accelOut));
    motor_model motor (.clk(clk), .arst_n(arst_n), .periodCyc(periodCyc), .hall(modelHall),
        .tachoPulse(tachoPulse));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] w, output logic [31:0] r,
        output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= w;
        @(posedge clk);
        penable <= 1'b1;
        // No wait-state count assumed: only the bench timeout ends a hung transfer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic ctrl(input logic run, input logic dir, input logic [3:0] tmo);
        logic [31:0] r;
        logic e;
        apb(1'b1, CTRL_OFS, 32'(tmo) << CTRL_TMO_LSB | 32'(dir) << CTRL_DIR_BIT | 32'(run), r, e);
        check("ctrl write err", 32'(e), 0);
    endtask : ctrl
    task automatic status(output logic [31:0] r);
        logic e;
        apb(1'b0, STATUS_OFS, 0, r, e);
    endtask : status
    task automatic done(input string name);
        $display("test %s done", name);
    endtask : done
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        // Drive is held at zero by the asynchronous reset; checks start once it is released
        if (arst_n === 1'b1) begin
            check("phase overlap", 32'(drive.high & drive.low), 0);
        end
        // The locked-speed measurement alone takes about 97000 cycles
        if (cyc == 125000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        logic e;
        {arst_n, psel, penable, pwrite, overCurrent, hallBad} = '0;
        paddr = '0;
        pwdata = '0;
        periodCyc = '0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        check("drive at reset", 32'(drive), 0);
        check("flag at reset", 32'(speedLockFlag_n), 1);
        apb(1'b0, CTRL_OFS, 0, d, e);
        check("ctrl reset", d, 32'(TMO_RESET) << CTRL_TMO_LSB);
        status(d);
        check("duty reset", 32'(d[ST_DUTY_LSB+:8]), 32'(DUTY_RESET));
        apb(1'b0, 8'h0c, 0, d, e);
        check("unmapped err", 32'(e), 1);
        check("unmapped data", d, 0);
        apb(1'b1, STATUS_OFS, 32'hffff_ffff, d, e);
        check("status write err", 32'(e), 1);
        done("registers");
        ctrl(1'b1, 1'b0, 4'h1);
        repeat (UNIT - UNIT / 10) @(posedge clk);
        check("drive runs", 32'(drive.high != 0), 1);
        status(d);
        check("early shutdown", 32'(d[ST_SHUT_BIT]), 0);
        repeat (UNIT / 5) @(posedge clk);
        status(d);
        check("shutdown", 32'(d[ST_SHUT_BIT]), 1);
        check("low sides off", 32'(drive.low), 0);
        ctrl(1'b1, 1'b1, 4'h1);
        repeat (300) @(posedge clk);
        status(d);
        check("latched", 32'(d[ST_SHUT_BIT]), 1);
        ctrl(1'b0, 1'b1, 4'h1);
        status(d);
        check("stop clears", 32'(d[ST_SHUT_BIT]), 0);
        check("stop drive", 32'(drive), 0);
        ctrl(1'b1, 1'b1, 4'h1);
        repeat (UNIT / 2) @(posedge clk);
        status(d);
        check("short stop", 32'(d[ST_SHUT_BIT]), 1);
        ctrl(1'b0, 1'b1, 4'h1);
        repeat (STOP_MS_PER_UNIT * MSC + 100) @(posedge clk);
        ctrl(1'b1, 1'b1, 4'h1);
        repeat (UNIT - UNIT / 10) @(posedge clk);
        status(d);
        check("full stop", 32'(d[ST_SHUT_BIT]), 0);
        done("protection");
        ctrl(1'b1, 1'b1, 4'h0);
        repeat (UNIT) @(posedge clk);
        status(d);
        check("disabled", 32'(d[ST_SHUT_BIT]), 0);
        ctrl(1'b1, 1'b0, 4'h0);
        repeat (100) @(posedge clk);
        check("dead drive", 32'(drive), 0);
        status(d);
        check("changeover", 32'(d[ST_CHG_BIT]), 1);
        repeat (200) @(posedge clk);
        check("new dir drive", 32'(drive.high != 0), 1);
        overCurrent <= 1'b1;
        repeat (5) @(posedge clk);
        check("brake drive", 32'(drive), 32'({3'b111, 3'b000}));
        status(d);
        check("brake", 32'(d[ST_BRAKE_BIT]), 1);
        overCurrent <= 1'b0;
        hallBad <= 1'b1;
        repeat (5) @(posedge clk);
        check("bad hall", 32'(drive), 0);
        hallBad <= 1'b0;
        done("direction");
        status(d0);
        check("stalled accel", 32'(accelOut), 1);
        periodCyc <= 32'(10 * REF_DIV);
        @(posedge tachoPulse);
        @(posedge tachoPulse);
        // Shorter than a full target period to keep the run short
        periodCyc <= 32'(LOCKED_TICKS * REF_DIV);
        repeat (10) @(posedge clk);
        check("fast accel", 32'(accelOut), 0);
        check("fast flag", 32'(speedLockFlag_n), 1);
        status(d);
        check("duty down", 32'(d[ST_DUTY_LSB+:8] < d0[ST_DUTY_LSB+:8]), 1);
        @(posedge tachoPulse);
        repeat (10) @(posedge clk);
        check("locked flag", 32'(speedLockFlag_n), 0);
        apb(1'b0, PERIOD_OFS, 0, d, e);
        // A reference tick that falls in the edge-detect cycle is not counted
        check("period", 32'(d == 32'(LOCKED_TICKS) || d == 32'(LOCKED_TICKS - 1)), 1);
        done("speed");
        report_and_stop();
    end
endmodule : tb
